/* File: pdsf_framer.sv */
// Link-side sampler: synchronises both bus lines and flags start and stop.
// Assumes link_clk samples several times per serial clock phase.
`timescale 1ns/10ps
module pdsf_framer (
    input wire logic link_clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    pdsf_link_if.framer lnk
);
    logic scl_meta_reg;
    logic sda_meta_reg;
    logic scl_sync_reg;
    logic sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic start_tgl_reg;
    logic stop_tgl_reg;
    logic scl_high;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_meta_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_meta_reg <= scl_i;
            sda_meta_reg <= sda_i;
            scl_sync_reg <= scl_meta_reg;
            sda_sync_reg <= sda_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    // Any data edge with the clock high both samples is framing
    assign scl_high = scl_sync_reg && scl_prev_reg;
    assign start_seen = scl_high && sda_prev_reg && !sda_sync_reg;
    assign stop_seen = scl_high && !sda_prev_reg && sda_sync_reg;

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_tgl_reg <= 1'b0;
            stop_tgl_reg <= 1'b0;
        end
        else
        begin
            if (start_seen)
            begin
                start_tgl_reg <= !start_tgl_reg;
            end
            if (stop_seen)
            begin
                stop_tgl_reg <= !stop_tgl_reg;
            end
        end
    end

    // Levels leave aligned with the toggles
    assign lnk.link_scl = scl_prev_reg;
    assign lnk.link_sda = sda_prev_reg;
    assign lnk.link_start_tgl = start_tgl_reg;
    assign lnk.link_stop_tgl = stop_tgl_reg;

    framing_only_a: assert property (@(posedge link_clk) disable iff (!nrst)
        (scl_sync_reg && scl_prev_reg && (sda_sync_reg != sda_prev_reg))
        |=> (start_tgl_reg != $past(start_tgl_reg)) || (stop_tgl_reg != $past(stop_tgl_reg)))
        else $error("data edge under high clock not framed");
    start_detect_a: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(sda_sync_reg) && scl_sync_reg && $past(scl_sync_reg)
        |=> $changed(start_tgl_reg) && $stable(stop_tgl_reg))
        else $error("start not flagged");
    stop_detect_a: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(sda_sync_reg) && scl_sync_reg && $past(scl_sync_reg)
        |=> $changed(stop_tgl_reg) && $stable(start_tgl_reg))
        else $error("stop not flagged");
endmodule

/* File: pdsf_host_model.sv */
// Host bus master model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module pdsf_host_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    localparam time T_Q = 1000;

    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // One clock period, master sets data only while the clock is low
    task automatic bit_xfer(input logic b, output logic s);
        scl = 1'b0;
        #T_Q sda_pull = !b;
        #T_Q scl = 1'b1;
        #T_Q s = sda_wire;
        #T_Q scl = 1'b0;
    endtask

    task automatic start_cond();
        #T_Q sda_pull = 1'b0;
        #T_Q scl = 1'b1;
        #T_Q sda_pull = 1'b1;
        #T_Q scl = 1'b0;
    endtask

    task automatic stop_cond();
        #T_Q sda_pull = 1'b1;
        #T_Q scl = 1'b1;
        #T_Q sda_pull = 1'b0;
        #T_Q;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], s);
        bit_xfer(1'b1, s);
        ack = !s;
    endtask

    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(!give_ack, s);
    endtask
endmodule

/* File: pdsf_link_if.sv */
// Carrier between the link-side framer, the crossing and the core.
// Link signals live on the link clock, core signals on the core clock.
`timescale 1ns/10ps
interface pdsf_link_if;
    logic link_scl;
    logic link_sda;
    logic link_start_tgl;
    logic link_stop_tgl;
    logic core_scl;
    logic core_sda;
    logic core_start;
    logic core_stop;
    logic core_scl_rise;
    logic core_scl_fall;

    modport framer (
        output link_scl,
        output link_sda,
        output link_start_tgl,
        output link_stop_tgl
    );
    modport xing (
        input link_scl,
        input link_sda,
        input link_start_tgl,
        input link_stop_tgl,
        output core_scl,
        output core_sda,
        output core_start,
        output core_stop,
        output core_scl_rise,
        output core_scl_fall
    );
    modport core (
        input core_scl,
        input core_sda,
        input core_start,
        input core_stop,
        input core_scl_rise,
        input core_scl_fall
    );
endinterface

/* File: pdsf_pkg.sv */
// Constants and types for the presence-detect serial framing front end.
// Assumes a 20 MHz core clock and a separate link sampling clock.
package pdsf_pkg;
    localparam int unsigned REF_CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned WRITE_CYCLE_MS = 10;
    localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (REF_CLK_HZ / MS_PER_S);
    localparam int unsigned BUSY_CNT_W = 18;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned SA_W = 3;
    localparam int unsigned WORD_ADDR_W = 8;
    localparam int unsigned XING_W = 4;
    localparam logic [XING_W-1:0] XING_IDLE = 4'h3;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;
    localparam logic [3:0] DEV_TYPE_MEM = 4'ha;
    localparam logic [7:0] MEM_RESET_VAL = 8'hff;
    localparam int unsigned SEL_TYPE_HI = 7;
    localparam int unsigned SEL_TYPE_LO = 4;
    localparam int unsigned SEL_SA_HI = 3;
    localparam int unsigned SEL_SA_LO = 1;
    localparam int unsigned SEL_RW = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TXACK = 3'b100,
        ST_TXNEXT = 3'b101,
        ST_WAIT = 3'b110
    } pdsf_state_t;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'b00,
        KIND_WORD = 2'b01,
        KIND_DATA = 2'b10
    } pdsf_kind_t;
endpackage

/* File: pdsf_top.sv */
// Top of the presence-detect serial front end: framing, byte engine, store.
// Assumes an external pull-up on the data line and a master-driven clock.
`timescale 1ns/10ps
// Summary of operation
// - Data line changes only while the serial clock is low.
// - A data edge while the clock is high is framing, never data.
// - Data falling with clock high is a start.
// - Everything is ignored until a start has been seen.
// - Data rising with clock high is a stop.
// - A stop abandons any transfer and returns to standby.
// - Receiver pulls data low on the ninth clock to acknowledge.
// - During the write cycle the device stays released and does not acknowledge.
module pdsf_top
    import pdsf_pkg::*;
#(
    parameter int unsigned WRITE_CYC = pdsf_pkg::WRITE_CYCLE_CYC,
    parameter int unsigned ADDR_W = pdsf_pkg::WORD_ADDR_W
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [pdsf_pkg::SA_W-1:0] sa_i,
    output logic standby,
    output logic write_busy
);
    import pdsf_pkg::*;

    localparam int unsigned MEM_DEPTH = 1 << ADDR_W;
    localparam logic [BUSY_CNT_W-1:0] BUSY_LOAD = BUSY_CNT_W'(WRITE_CYC - 1);
    localparam logic [BUSY_CNT_W-1:0] BUSY_DONE = '0;

    pdsf_link_if lnk();

    pdsf_framer u_framer (
        .link_clk(link_clk),
        .nrst(nrst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lnk(lnk)
    );

    pdsf_xing u_xing (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .lnk(lnk)
    );

    pdsf_state_t state_reg;
    pdsf_kind_t kind_reg;
    logic [3:0] bit_cnt_reg;
    logic [BYTE_W-1:0] shift_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic rw_reg;
    logic wrote_reg;
    logic sda_oe_reg;
    logic sda_o_reg;
    logic standby_reg;
    logic busy_reg;
    logic [BUSY_CNT_W-1:0] busy_cnt_reg;
    logic [SA_W-1:0] sa_meta_reg;
    logic [SA_W-1:0] sa_sync_reg;
    logic [BYTE_W-1:0] mem [MEM_DEPTH];
    logic start_p;
    logic stop_p;
    logic rise_p;
    logic fall_p;
    logic byte_done;
    logic sel_match;
    logic mem_we;
    logic busy_go;

    // Open-drain drive: enable pulls low
    function automatic logic pull_for(input logic data_bit);
        pull_for = !data_bit;
    endfunction

    assign start_p = ce && lnk.core_start;
    assign stop_p = ce && lnk.core_stop;
    assign rise_p = ce && lnk.core_scl_rise;
    assign fall_p = ce && lnk.core_scl_fall;
    assign byte_done = fall_p && (state_reg == ST_RX) && (bit_cnt_reg == BIT_FULL);
    assign sel_match = (shift_reg[SEL_TYPE_HI:SEL_TYPE_LO] == DEV_TYPE_MEM)
        && (shift_reg[SEL_SA_HI:SEL_SA_LO] == sa_sync_reg);
    assign mem_we = byte_done && (kind_reg == KIND_DATA) && !start_p && !stop_p;
    assign busy_go = stop_p && wrote_reg && !busy_reg;

    // Strap pins from outside the clock domain
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sa_meta_reg <= '0;
            sa_sync_reg <= '0;
        end
        else if (ce)
        begin
            sa_meta_reg <= sa_i;
            sa_sync_reg <= sa_meta_reg;
        end
    end

    // Internal write cycle timer, started by the stop after a write
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= BUSY_DONE;
        end
        else if (ce)
        begin
            if (busy_go)
            begin
                busy_reg <= 1'b1;
                busy_cnt_reg <= BUSY_LOAD;
            end
            else if (busy_reg)
            begin
                if (busy_cnt_reg == BUSY_DONE)
                begin
                    busy_reg <= 1'b0;
                end
                else
                begin
                    busy_cnt_reg <= busy_cnt_reg - 1'b1;
                end
            end
        end
    end

    // Store behind the byte engine
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < MEM_DEPTH; i++)
            begin
                mem[i] <= MEM_RESET_VAL;
            end
        end
        else if (mem_we)
        begin
            mem[addr_reg] <= shift_reg;
        end
    end

    // Write flag, set when a data byte is stored, cleared by the next stop
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrote_reg <= 1'b0;
        end
        else if (stop_p)
        begin
            wrote_reg <= 1'b0;
        end
        else if (mem_we)
        begin
            wrote_reg <= 1'b1;
        end
    end

    // Byte engine
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            kind_reg <= KIND_ADDR;
            bit_cnt_reg <= BIT_ZERO;
            shift_reg <= '0;
            addr_reg <= '0;
            rw_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            standby_reg <= 1'b1;
        end
        else if (stop_p)
        begin
            state_reg <= ST_IDLE;
            standby_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
        end
        else if (start_p)
        begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= BIT_ZERO;
            kind_reg <= KIND_ADDR;
            if (busy_reg)
            begin
                state_reg <= ST_IDLE;
            end
            else
            begin
                state_reg <= ST_RX;
                standby_reg <= 1'b0;
            end
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                ST_RX:
                begin
                    if (rise_p && (bit_cnt_reg != BIT_FULL))
                    begin
                        shift_reg <= {shift_reg[BYTE_W-2:0], lnk.core_sda};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end
                    else if (byte_done)
                    begin
                        if (kind_reg != KIND_ADDR)
                        begin
                            state_reg <= ST_ACK;
                            sda_oe_reg <= 1'b1;
                            if (kind_reg == KIND_WORD)
                            begin
                                addr_reg <= shift_reg[ADDR_W-1:0];
                            end
                            else
                            begin
                                addr_reg <= addr_reg + 1'b1;
                            end
                        end
                        else if (sel_match)
                        begin
                            state_reg <= ST_ACK;
                            sda_oe_reg <= 1'b1;
                            rw_reg <= shift_reg[SEL_RW];
                        end
                        else
                        begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (fall_p)
                    begin
                        bit_cnt_reg <= BIT_ZERO;
                        if (rw_reg && (kind_reg == KIND_ADDR))
                        begin
                            state_reg <= ST_TX;
                            shift_reg <= mem[addr_reg];
                            addr_reg <= addr_reg + 1'b1;
                            sda_oe_reg <= pull_for(mem[addr_reg][BYTE_W-1]);
                        end
                        else
                        begin
                            state_reg <= ST_RX;
                            sda_oe_reg <= 1'b0;
                            kind_reg <= (kind_reg == KIND_ADDR) ? KIND_WORD : KIND_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (fall_p)
                    begin
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            state_reg <= ST_TXACK;
                            sda_oe_reg <= 1'b0;
                        end
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                            shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0};
                            sda_oe_reg <= pull_for(shift_reg[BYTE_W-2]);
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (rise_p)
                    begin
                        state_reg <= lnk.core_sda ? ST_WAIT : ST_TXNEXT;
                    end
                end
                ST_TXNEXT:
                begin
                    if (fall_p)
                    begin
                        state_reg <= ST_TX;
                        bit_cnt_reg <= BIT_ZERO;
                        shift_reg <= mem[addr_reg];
                        addr_reg <= addr_reg + 1'b1;
                        sda_oe_reg <= pull_for(mem[addr_reg][BYTE_W-1]);
                    end
                end
                ST_WAIT:
                begin
                    sda_oe_reg <= 1'b0;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Drive value is always low; the enable carries the data
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sda_o_reg <= 1'b0;
        end
        else
        begin
            sda_o_reg <= 1'b0;
        end
    end

    assign sda_o = sda_o_reg;
    assign sda_oe = sda_oe_reg;
    assign standby = standby_reg;
    assign write_busy = busy_reg;

    sda_change_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(sda_oe_reg) && !$past(start_p) && !$past(stop_p)
        |-> $past(fall_p) && !lnk.core_scl)
        else $error("data drive changed outside clock low");
    idle_ignore_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == ST_IDLE && !start_p |=> state_reg == ST_IDLE && !sda_oe_reg)
        else $error("left idle without start");
    start_accept_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_p && !stop_p && !busy_reg |=> state_reg == ST_RX && bit_cnt_reg == BIT_ZERO
        && !standby_reg)
        else $error("start not accepted");
    stop_standby_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        stop_p |=> state_reg == ST_IDLE && standby_reg && !sda_oe_reg)
        else $error("stop did not return to standby");
    ack_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        byte_done && !start_p && !stop_p && (kind_reg != KIND_ADDR || sel_match)
        |=> state_reg == ST_ACK && sda_oe_reg)
        else $error("ninth clock not acknowledged");
    tx_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == ST_TXACK |-> !sda_oe_reg)
        else $error("data line held during master acknowledge");
    busy_nack_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        busy_reg |-> !sda_oe_reg && state_reg == ST_IDLE)
        else $error("active during write cycle");
    busy_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        busy_go |=> busy_reg && busy_cnt_reg == BUSY_LOAD)
        else $error("write cycle not started by stop");
endmodule

/* File: pdsf_xing.sv */
// Carries link levels and start/stop toggles into the core clock domain.
// Assumes the link signals come from flops on the link clock.
`timescale 1ns/10ps
module pdsf_xing
    import pdsf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    pdsf_link_if.xing lnk
);
    logic [XING_W-1:0] meta_reg;
    logic [XING_W-1:0] sync_reg;
    logic scl_prev_reg;
    logic start_prev_reg;
    logic stop_prev_reg;

    // Order: start toggle, stop toggle, clock, data
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= XING_IDLE;
            sync_reg <= XING_IDLE;
            scl_prev_reg <= 1'b1;
            start_prev_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
        end
        else if (ce)
        begin
            meta_reg <= {lnk.link_start_tgl, lnk.link_stop_tgl, lnk.link_scl, lnk.link_sda};
            sync_reg <= meta_reg;
            start_prev_reg <= sync_reg[3];
            stop_prev_reg <= sync_reg[2];
            scl_prev_reg <= sync_reg[1];
        end
    end

    assign lnk.core_start = sync_reg[3] ^ start_prev_reg;
    assign lnk.core_stop = sync_reg[2] ^ stop_prev_reg;
    assign lnk.core_scl = sync_reg[1];
    assign lnk.core_sda = sync_reg[0];
    assign lnk.core_scl_rise = sync_reg[1] && !scl_prev_reg;
    assign lnk.core_scl_fall = !sync_reg[1] && scl_prev_reg;
endmodule

/* File: presence_detect_serial_framing_test.sv */
// Self-checking bench for the serial framing front end and its byte engine.
// Assumes the host model drives the bus and the data wire has a pull-up.
`timescale 1ns/10ps
module presence_detect_serial_framing_test;
    import pdsf_pkg::*;
    localparam int unsigned WCYC = 200;
    localparam logic [2:0] SA = 3'h5;
    localparam logic [7:0] SEL_W = {DEV_TYPE_MEM, SA, 1'b0};
    typedef struct packed {logic [7:0] addr; logic [7:0] data;} pdsf_row_t;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst;
    logic ce;
    logic [SA_W-1:0] sa_i;
    logic scl;
    logic sda_pull;
    logic sda_o;
    logic sda_oe;
    logic standby;
    logic write_busy;
    logic sda_wire;
    logic ack;
    logic [7:0] rd;
    logic [7:0] rd2;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    pdsf_row_t rows [4] = '{'{8'h00, 8'h5a}, '{8'h01, 8'ha5}, '{8'h0f, 8'h3c}, '{8'h07, 8'h00}};

    assign sda_wire = !sda_pull && (sda_oe ? sda_o : 1'b1);
    always #25 ref_clk = ~ref_clk;
    initial
    begin
        #7;
        forever #40 link_clk = ~link_clk;
    end

    pdsf_top #(.WRITE_CYC(WCYC), .ADDR_W(4)) u_pdsf_top (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .link_clk(link_clk),
        .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
        .sa_i(sa_i), .standby(standby), .write_busy(write_busy)
    );
    pdsf_host_model u_pdsf_host_model (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

    task automatic stop_test();
        $display("Checks done %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp_flag(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_test(input string name);
        $display("Test %s done", name);
    endtask

    task automatic sta();
        u_pdsf_host_model.start_cond();
    endtask

    task automatic sto();
        u_pdsf_host_model.stop_cond();
    endtask

    task automatic wb(input logic [7:0] d, input logic exp_ack, input string name);
        u_pdsf_host_model.write_byte(d, ack);
        cmp_flag(name, exp_ack, ack);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < WCYC + 50; i++)
        begin
            if (write_busy === 1'b0)
                break;
            @(negedge ref_clk);
        end
        cmp_flag("write_busy end", 1'b0, write_busy);
    endtask

    task automatic write_mem(input logic [7:0] a, input logic [7:0] d, input logic wait_done);
        sta();
        wb(SEL_W, 1'b1, "select ack");
        wb(a, 1'b1, "word ack");
        wb(d, 1'b1, "data ack");
        sto();
        cmp_flag("standby", 1'b1, standby);
        cmp_flag("write_busy", 1'b1, write_busy);
        if (wait_done)
            wait_idle();
    endtask

    task automatic read_mem(input logic [7:0] a, input logic two, output logic [7:0] d,
                            output logic [7:0] d2);
        sta();
        wb(SEL_W, 1'b1, "select ack");
        wb(a, 1'b1, "word ack");
        sta();
        wb(SEL_W | 8'h01, 1'b1, "read select ack");
        u_pdsf_host_model.read_byte(two, d);
        if (two)
            u_pdsf_host_model.read_byte(1'b0, d2);
        sto();
    endtask

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            n_errors++;
            stop_test();
        end
    end

    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        sa_i = SA;
        repeat (16) @(negedge ref_clk);
        cmp_flag("reset standby", 1'b1, standby);
        cmp_flag("reset oe", 1'b0, sda_oe);
        cmp_flag("reset busy", 1'b0, write_busy);
        cmp_flag("reset drive", 1'b0, sda_o);
        nrst = 1'b1;
        repeat (8) @(negedge ref_clk);
        end_test("reset");
        foreach (rows[i])
        begin
            write_mem(rows[i].addr, rows[i].data, 1'b1);
            read_mem(rows[i].addr, 1'b0, rd, rd2);
            cmp_byte("read back", rows[i].data, rd);
        end
        end_test("rows");
        // Select sent with no start in front must be ignored
        wb(SEL_W, 1'b0, "unframed ack");
        sto();
        sta();
        cmp_flag("active", 1'b0, standby);
        repeat (3) u_pdsf_host_model.bit_xfer(1'b1, ack);
        sta();
        wb(SEL_W, 1'b1, "restart ack");
        sto();
        end_test("framing");
        sta();
        wb(SEL_W ^ 8'h02, 1'b0, "other strap ack");
        sto();
        end_test("strap");
        // Start seen while the core is frozen is taken once it runs again
        ce = 1'b0;
        sta();
        cmp_flag("frozen standby", 1'b1, standby);
        ce = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmp_flag("thawed standby", 1'b0, standby);
        sto();
        cmp_flag("thawed stop", 1'b1, standby);
        end_test("clock enable");
        // Stop abandons a half-sent data byte
        sta();
        wb(SEL_W, 1'b1, "select ack");
        wb(8'h03, 1'b1, "word ack");
        repeat (4) u_pdsf_host_model.bit_xfer(1'b0, ack);
        sto();
        cmp_flag("abort standby", 1'b1, standby);
        cmp_flag("abort busy", 1'b0, write_busy);
        read_mem(8'h03, 1'b0, rd, rd2);
        cmp_byte("abort store", MEM_RESET_VAL, rd);
        end_test("abort");
        write_mem(8'h08, 8'h99, 1'b0);
        sta();
        cmp_flag("busy standby", 1'b1, standby);
        wb(SEL_W, 1'b0, "busy ack");
        sto();
        wait_idle();
        read_mem(8'h08, 1'b0, rd, rd2);
        cmp_byte("busy store", 8'h99, rd);
        end_test("busy");
        read_mem(8'h00, 1'b1, rd, rd2);
        cmp_byte("seq first", 8'h5a, rd);
        cmp_byte("seq second", 8'ha5, rd2);
        end_test("sequential");
        stop_test();
    end
endmodule
